// File: rtl/odcm_defs.svh
// constants for the on-demand clock modulation block
// assumes inclusion by the package and the top module
`ifndef ODCM_DEFS_SVH
`define ODCM_DEFS_SVH
// control register field positions
`define ODCM_EN_BIT 4
`define ODCM_DUTY_LSB 1
`define ODCM_DUTY_MSB 3
`define ODCM_EXT_BIT 0
// control register reset value
`define ODCM_CTRL_RST 64'h0000_0000_0000_0000
// modulation frame: 16 slots of one cycle each
`define ODCM_SLOT_W 4
`define ODCM_SLOTS 5'h10
`endif

// File: rtl/odcm_pkg.sv
// types for the on-demand clock modulation block
// assumes nothing beyond the defs header
`include "odcm_defs.svh"
package odcm_pkg;
  // one modulation request: enable and duty in sixteenths
  typedef struct packed {
    logic en;
    logic [3:0] duty;
  } odcm_req_type;
  // request source selected by the arbiter
  typedef enum logic [3:0] {
    SRC_FULL = 4'h1,
    SRC_REG = 4'h2,
    SRC_IO = 4'h4,
    SRC_TCC = 4'h8
  } odcm_src_type;
endpackage

// File: rtl/odcm_gate.sv
// per-core clock gate enable generator
// assumes a slot counter shared by all cores
`timescale 1ns/10ps
module odcm_gate
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // frame position and request
  input wire logic [3:0] slot,
  input wire odcm_pkg::odcm_req_type req,
  // gate enable to the core clock
  output logic clk_en
);
  import odcm_pkg::*;

  logic clk_en_next;

  // zero duty means full rate; otherwise run duty slots of sixteen
  always_comb
  begin
    if (!req.en || req.duty == 4'h0)
      clk_en_next = 1'b1;
    else
      clk_en_next = (slot < req.duty);
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      clk_en <= 1'b1;
    else
      clk_en <= clk_en_next;
  end
endmodule

// File: rtl/odcm_top.sv
// on-demand clock modulation with register, io and thermal arbitration
// assumes register writes arrive as a per-core write strobe with data
`timescale 1ns/10ps
`include "odcm_defs.svh"
// Functional notes
// [RQ1] enable bit starts modulation at once
// [RQ2] duty taken from bits three to one
// [RQ3] steps 12.5 or 6.25, reported to software
// [RQ4] register request gates its own core only
// [RQ5] io request gates every core together
// [RQ6] legacy software writes chipset clock control
// [RQ7] thermal circuit duty overrides on-demand duty
// [RQ8] io duty wins over register duty
// [RQ9] runs alongside thermal monitor, kept separate; here the thermal duty shares the odcm_gate path
// [RQ10] platform must not rely on this throttling
// [RQ11] idle paths give full clock
module odcm_top
  import odcm_pkg::*;
#(
  parameter int NCORE = 4,
  parameter logic FINE_STEP = 1'b1
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // per-core control register access
  input wire logic [NCORE-1:0] ctrl_wr,
  input wire logic [63:0] ctrl_wdata,
  input wire logic [$clog2(NCORE+1)-1:0] ctrl_rsel,
  output logic [63:0] ctrl_rdata,
  // chipset processor clock control emulation
  input wire odcm_pkg::odcm_req_type io_req,
  // thermal control circuit
  input wire logic tcc_active,
  input wire logic [3:0] tcc_duty,
  // capability report and gates
  output logic fine_step_cap,
  output logic [NCORE-1:0] core_clk_en,
  output logic [NCORE-1:0] io_mode
);
  import odcm_pkg::*;

  // stored control registers, one per core
  logic [63:0] ctrl_reg [NCORE];
  logic [63:0] ctrl_next [NCORE];
  // frame slot counter
  logic [3:0] slot_reg;
  logic [3:0] slot_next;
  // read data register
  logic [63:0] rdata_reg;
  logic [63:0] rdata_next;
  // io mode flags register
  logic [NCORE-1:0] iom_reg;
  logic [NCORE-1:0] iom_next;
  // arbitrated request per core
  odcm_req_type sel_req [NCORE];

  // register writes; only the addressed core changes
  always_comb
  begin
    for (int i = 0; i < NCORE; i++)
    begin
      ctrl_next[i] = ctrl_reg[i];
      // [RQ1] enable write honoured
      if (ctrl_wr[i])
        ctrl_next[i] = ctrl_wdata;
    end
  end

  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < NCORE; i++)
    begin
      if (!nrst)
        ctrl_reg[i] <= `ODCM_CTRL_RST;
      else
        ctrl_reg[i] <= ctrl_next[i];
    end
  end

  // free-running slot counter, wraps every sixteen cycles
  always_comb
  begin
    slot_next = slot_reg + 4'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      slot_reg <= 4'h0;
    else
      slot_reg <= slot_next;
  end

  // arbitration: thermal first, then io, then the core's register
  always_comb
  begin
    iom_next = '0;
    for (int i = 0; i < NCORE; i++)
    begin
      // [RQ11] full clock default
      sel_req[i] = '{en: 1'b0, duty: 4'h0};
      if (tcc_active)
        // [RQ7] thermal duty overrides
        sel_req[i] = '{en: 1'b1, duty: tcc_duty};
      else if (io_req.en)
      begin
        // [RQ5] [RQ8] io applies to all cores
        sel_req[i] = io_req;
        iom_next[i] = 1'b1;
      end
      else if (ctrl_reg[i][`ODCM_EN_BIT])
      begin
        // [RQ2] [RQ3] [RQ4] own register duty
        sel_req[i].en = 1'b1;
        sel_req[i].duty = FINE_STEP ?
          {ctrl_reg[i][`ODCM_DUTY_MSB:`ODCM_DUTY_LSB],
           ctrl_reg[i][`ODCM_EXT_BIT]} :
          {ctrl_reg[i][`ODCM_DUTY_MSB:`ODCM_DUTY_LSB], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      iom_reg <= '0;
    else
      iom_reg <= iom_next;
  end

  // read mux, registered; an out of range select reads zero
  always_comb
  begin
    rdata_next = 64'h0;
    for (int i = 0; i < NCORE; i++)
      if (ctrl_rsel == i[$clog2(NCORE+1)-1:0])
        rdata_next = ctrl_reg[i];
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      rdata_reg <= 64'h0;
    else
      rdata_reg <= rdata_next;
  end

  // one gate per core; this is the only path to the core clocks,
  // so the thermal control circuit duty is gated through it as well
  // [RQ9] gating path shared with the thermal duty, not separate
  for (genvar g = 0; g < NCORE; g++)
  begin : gen_gate
    odcm_gate u_gate (
      .core_clk(core_clk),
      .nrst(nrst),
      .slot(slot_reg),
      .req(sel_req[g]),
      .clk_en(core_clk_en[g])
    );
  end

  assign ctrl_rdata = rdata_reg;
  assign io_mode = iom_reg;

  // [RQ3] capability from a flop
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      fine_step_cap <= 1'b0;
    else
      fine_step_cap <= FINE_STEP;
  end

  // checks
  // [RQ11] idle gives full clock
  idle_full_a: assert property ( // [RQ11]
    @(posedge core_clk) disable iff (!nrst)
    (!tcc_active && !io_req.en && !ctrl_reg[0][`ODCM_EN_BIT])
    |=> core_clk_en[0])
    else $error("idle core clock gated");
  // [RQ7] thermal duty closes the late slots
  tcc_gate_a: assert property ( // [RQ7]
    @(posedge core_clk) disable iff (!nrst)
    (tcc_active && tcc_duty != 4'h0 && slot_reg >= tcc_duty)
    |=> !core_clk_en[0])
    else $error("thermal duty not applied");
  // [RQ5] io sets mode on all cores
  io_all_a: assert property ( // [RQ5]
    @(posedge core_clk) disable iff (!nrst)
    (io_req.en && !tcc_active) |=> &io_mode)
    else $error("io path not applied to all cores");
  // [RQ8] io wins over register; a lower register duty would
  // close the gate in early slots that the io duty keeps open
  io_wins_a: assert property ( // [RQ8]
    @(posedge core_clk) disable iff (!nrst)
    (io_req.en && !tcc_active && slot_reg < io_req.duty)
    |=> core_clk_en[0])
    else $error("register duty beat io duty");
  // [RQ7] thermal clears io mode
  tcc_over_io_a: assert property ( // [RQ7]
    @(posedge core_clk) disable iff (!nrst)
    tcc_active |=> io_mode == '0)
    else $error("io mode during thermal");
  // [RQ1] enable write closes the gate within one frame, unless
  // a later write or a higher priority request takes over first
  en_quick_a: assert property ( // [RQ1]
    @(posedge core_clk) disable iff (!nrst)
    (ctrl_wr[0] && ctrl_wdata[`ODCM_EN_BIT]
     && ctrl_wdata[`ODCM_DUTY_MSB:`ODCM_DUTY_LSB] != 3'h0)
    |-> ##[1:17] (!core_clk_en[0] || tcc_active || io_req.en
      || ctrl_wr[0]))
    else $error("enable did not modulate");
  // [RQ4] other core unaffected
  own_core_a: assert property ( // [RQ4]
    @(posedge core_clk) disable iff (!nrst)
    (!tcc_active && !io_req.en && !ctrl_reg[1][`ODCM_EN_BIT])
    |=> core_clk_en[1])
    else $error("foreign register gated core");
  // [RQ2] register duty of four sixteenths closes slot five
  reg_duty_a: assert property ( // [RQ2]
    @(posedge core_clk) disable iff (!nrst)
    (!tcc_active && !io_req.en && ctrl_reg[0][4:0] == 5'h14
     && slot_reg == 4'h5) |=> !core_clk_en[0])
    else $error("register duty ignored");
  io_cov: cover property (@(posedge core_clk) io_req.en && !tcc_active);
  tcc_cov: cover property (@(posedge core_clk) tcc_active);
  reg_cov: cover property (@(posedge core_clk)
    ctrl_reg[0][`ODCM_EN_BIT] && !core_clk_en[0]);
endmodule

// File: verif/odcm_tb_top.sv
// self-checking bench for the clock modulation block, two cores
// assumes the slot counter phase is unknown, so enables are counted per frame
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  failures++; $display("wrong value t=%0t got %h exp %h", $time, a, e); \
  end end
module odcm_tb_top;
  import odcm_pkg::*;
  // one stimulus row with its expected frame counts
  typedef struct {
    logic w; logic [63:0] wd; odcm_req_type io; logic thermal_control_circuit;
    logic [3:0] td; logic [4:0] c0; logic [4:0] c1; logic [1:0] iom;
  } odcm_row_type;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] ctrl_wr = 2'h0;
  logic [63:0] ctrl_wdata = 64'h0;
  logic [1:0] ctrl_rsel = 2'h0;
  logic [63:0] ctrl_rdata;
  odcm_req_type io_req = '0;
  logic tcc_active = 1'b0;
  logic [3:0] tcc_duty = 4'h0;
  logic fine_step_cap;
  logic [1:0] core_clk_en;
  logic [1:0] io_mode;
  int failures = 0;
  int samples_checked = 0;
  int n0;
  int n1;
  odcm_row_type rows [6];
  odcm_top #(.NCORE(2), .FINE_STEP(1'b1)) odcm_top_i (
    .core_clk(core_clk), .nrst(nrst), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .ctrl_rsel(ctrl_rsel), .ctrl_rdata(ctrl_rdata),
    .io_req(io_req), .tcc_active(tcc_active), .tcc_duty(tcc_duty),
    .fine_step_cap(fine_step_cap), .core_clk_en(core_clk_en),
    .io_mode(io_mode));
  // 200 MHz clock
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end
  // counts and verdict, the single place the run ends
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // enable-high cycles of each core over one whole 16-cycle frame
  task automatic count_frame();
    n0 = 0;
    n1 = 0;
    repeat (16)
    begin
      @(negedge core_clk);
      n0 += core_clk_en[0];
      n1 += core_clk_en[1];
    end
  endtask
  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    #20000;
    failures++;
    final_report();
  end
  initial
  begin
    // write, data, io request, thermal, expected counts, io following
    // io rows stand in for legacy chipset clock control writes
    rows[0] = '{1'b0, 64'h00, '{1'b0, 4'h0}, 1'b0, 4'h0, 5'h10, 5'h10, 2'h0};
    rows[1] = '{1'b1, 64'h14, '{1'b0, 4'h0}, 1'b0, 4'h0, 5'h04, 5'h10, 2'h0};
    rows[2] = '{1'b1, 64'h13, '{1'b0, 4'h0}, 1'b0, 4'h0, 5'h03, 5'h10, 2'h0};
    rows[3] = '{1'b0, 64'h13, '{1'b1, 4'h6}, 1'b0, 4'h0, 5'h06, 5'h06, 2'h3};
    rows[4] = '{1'b0, 64'h13, '{1'b1, 4'h6}, 1'b1, 4'hA, 5'h0A, 5'h0A, 2'h0};
    rows[5] = '{1'b1, 64'h10, '{1'b0, 4'h0}, 1'b0, 4'h0, 5'h10, 5'h10, 2'h0};
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    // full clock and cleared register after reset
    `CHK(core_clk_en, 2'h3) // reset gates
    `CHK(ctrl_rdata, 64'h0) // reset value
    `CHK(fine_step_cap, 1'b1) // step report
    $display("reset test done");
    foreach (rows[i])
    begin
      @(posedge core_clk);
      ctrl_wr <= {1'b0, rows[i].w};
      ctrl_wdata <= rows[i].wd;
      io_req <= rows[i].io;
      // thermal is driven apart from the on-demand requests
      tcc_active <= rows[i].thermal_control_circuit;
      tcc_duty <= rows[i].td;
      @(posedge core_clk);
      ctrl_wr <= 2'h0;
      repeat (4) @(posedge core_clk);
      count_frame();
      `CHK(n0[4:0], rows[i].c0) // own duty
      `CHK(n1[4:0], rows[i].c1) // other core
      `CHK(ctrl_rdata, rows[i].wd) // register readback
      `CHK(io_mode, rows[i].iom) // io path followed
      $display("row %0d done", i);
    end
    // back-to-back writes: the second one wins on core1
    @(posedge core_clk);
    ctrl_wr <= 2'h2;
    ctrl_wdata <= 64'h18;
    @(posedge core_clk);
    ctrl_wdata <= 64'h12;
    @(posedge core_clk);
    ctrl_wr <= 2'h0;
    ctrl_rsel <= 2'h1;
    repeat (4) @(posedge core_clk);
    count_frame();
    `CHK(n1[4:0], 5'h02) // last write taken
    `CHK(n0[4:0], 5'h10) // core0 unaffected
    `CHK(ctrl_rdata, 64'h12) // core1 readback
    // select past the last core reads zero
    @(posedge core_clk);
    ctrl_rsel <= 2'h3;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(ctrl_rdata, 64'h0) // no such core
    $display("awkward test done");
    // second reset in mid-run, io active and core1 throttled
    @(posedge core_clk);
    io_req <= '{en: 1'b1, duty: 4'h6};
    ctrl_rsel <= 2'h1;
    @(posedge core_clk);
    nrst <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    `CHK(core_clk_en, 2'h3) // gates open in reset
    `CHK(io_mode, 2'h0) // io mode cleared
    `CHK(fine_step_cap, 1'b0) // report cleared
    `CHK(ctrl_rdata, 64'h0) // read data cleared
    // io drops a cycle before release so no check straddles it
    @(posedge core_clk);
    io_req <= '0;
    @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    count_frame();
    `CHK(n0[4:0], 5'h10) // core0 full clock
    `CHK(n1[4:0], 5'h10) // core1 register cleared
    `CHK(ctrl_rdata, 64'h0) // register back to reset
    `CHK(fine_step_cap, 1'b1) // report restored
    $display("mid-run reset test done");
    final_report();
  end
endmodule
